// [hw/spi_flash_read_program_erase.sv]
// Serial flash instruction sequencer: reads, page program, sector and block erase.
// Assumes the host drives chip select and serial clock; the array lives on the system clock.
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"

// Function
// - Opcode 03h plus 24-bit address, MSB first, returns data from that address.
// - Opcode and address sampled on rising clock; data driven on falling clock, MSB first.
// - Read address steps up after every byte until chip select rises.
// - Reads arriving while a program, erase or status write runs are ignored.
// - Opcode 0Bh inserts eight dummy clocks after the address; output meaningless then.
// - Opcode 3Bh returns two data bits per clock on both lines.
// - Dual output read has eight dummy clocks; input values then are ignored.
// - Dual data: line one carries bits 7,5,3,1; line zero bits 6,4,2,0.
// - Opcode BBh takes address two bits per clock and returns two bits per clock.
// - Dual address: odd bits on line one, even on line zero, highest first.
// - Opcode 02h programs one to 256 bytes into one page.
// - Page program refused unless the write enable latch is set.
// - Page loading wraps within the page; excess bytes overwrite earlier ones.
// - Page program runs only if chip select rises on a byte boundary.
// - Program cycle is self-timed with busy high throughout.
// - Write enable latch clears when a program cycle completes.
// - Page program into a protected region is skipped.
// - Opcode 20h erases the addressed 4 KB sector to FFh, needs write enable.
// - Sector erase needs chip select rise after the address and no protection.
// - Opcode D8h erases the addressed 64 KB block to FFh, needs write enable.
// - Block erase needs chip select rise after the address and no protection.
module spi_flash_read_program_erase import flash_seq_pkg::*; (
  // System clock and reset
  input wire logic clock,
  input wire logic srst,
  // Write enable and protection
  input wire logic write_enable_set,
  input wire logic write_enable_clear,
  input wire logic status_write_busy,
  input wire logic sector_granular_protect,
  input wire logic top_bottom_protect,
  input wire logic block_protect_2,
  input wire logic block_protect_1,
  input wire logic block_protect_0,
  // Status
  output logic write_enable_latch,
  output logic busy,
  // Serial link
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic dual_line_zero_in,
  output logic dual_line_zero_out,
  output logic dual_line_zero_oe,
  input wire logic dual_line_one_in,
  output logic dual_line_one_out,
  output logic dual_line_one_oe
);

  // Protection test of a byte range against the protect settings
  function automatic logic prot_hit(
    input logic [`ADDR_W-1:0] base,
    input logic [16:0] last,
    input logic sec,
    input logic tb,
    input logic [2:0] bp
  );
    logic [21:0] size;
    logic [21:0] hi;
    size = 22'h00_0000;
    hi = {1'b0, base} + {5'h00, last};
    if (bp == 3'h7) begin
      size = `MEM_BYTES;
    end else if (bp != 3'h0) begin
      size = sec ? (`SECTOR_SIZE << (bp - 3'h1)) : (`BLOCK_SIZE << (bp - 3'h1));
      if (size > `MEM_BYTES) begin
        size = `MEM_BYTES;
      end
    end
    if (size == 22'h00_0000) begin
      prot_hit = 1'b0;
    end else if (tb) begin
      prot_hit = {1'b0, base} < size;
    end else begin
      prot_hit = hi >= (`MEM_BYTES - size);
    end
  endfunction : prot_hit

  // Read data start edge for each read opcode
  function automatic logic [15:0] rd_start(input logic [7:0] op);
    rd_start = `CNT_MAX;
    if (op == `OP_READ) begin
      rd_start = `RD_START_NORMAL;
    end else if (op == `OP_FAST_READ || op == `OP_DUAL_OUT_READ) begin
      rd_start = `RD_START_FAST;
    end else if (op == `OP_DUAL_IO_READ) begin
      rd_start = `RD_START_DUAL_IO;
    end
  endfunction : rd_start

  // Opcodes that take a single line address
  function automatic logic single_addr_op(input logic [7:0] op);
    single_addr_op = 1'b0;
    if (op == `OP_READ || op == `OP_FAST_READ || op == `OP_DUAL_OUT_READ) begin
      single_addr_op = 1'b1;
    end else if (op == `OP_PAGE_PROGRAM || op == `OP_SECTOR_ERASE || op == `OP_BLOCK_ERASE) begin
      single_addr_op = 1'b1;
    end
  endfunction : single_addr_op

  // Opcodes that return data on both lines
  function automatic logic dual_data_op(input logic [7:0] op);
    dual_data_op = 1'b0;
    if (op == `OP_DUAL_OUT_READ || op == `OP_DUAL_IO_READ) begin
      dual_data_op = 1'b1;
    end
  endfunction : dual_data_op

  // Array, written on the system clock only
  logic [7:0] mem [0:`MEM_DEPTH-1];
  // Page load buffer, written on the serial clock only
  logic [7:0] pbuf [0:255];

  // Serial clock domain state
  logic frame_r;
  // Starts known so the core sees the first frame
  logic frame_tog_r = 1'b0;
  logic [15:0] cnt_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;
  logic [7:0] mode_r;
  logic ignore_r;
  logic busy_l1_r;
  logic busy_l2_r;
  logic [7:0] pp_sh_r;
  logic [7:0] pp_ptr_r;
  logic [255:0] pp_mask_r;
  logic rd_active_r;
  logic [2:0] rd_pos_r;
  logic [`ADDR_W-1:0] rd_addr_r;

  // System clock domain state
  core_state_t state_r;
  core_state_t state_nxt;
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic seen_tog_r;
  logic wel_r;
  logic wel_nxt;
  logic busy_r;
  logic [`ADDR_W-1:0] base_r;
  logic [16:0] last_r;
  logic [16:0] ptr_r;
  logic [16:0] ptr_nxt;

  // Frame decode on the serial clock
  wire first_w = ~frame_r;
  wire [15:0] cnt_eff_w = first_w ? 16'h0000 : cnt_r;
  wire [15:0] cnt_nxt = (cnt_eff_w == `CNT_MAX) ? cnt_eff_w : cnt_eff_w + 16'h0001;
  wire op_done_w = cnt_eff_w > `CNT_OPCODE_LAST;
  wire is_dual_io_w = op_done_w && op_r == `OP_DUAL_IO_READ;
  wire is_single_addr_w = op_done_w && single_addr_op(op_r);
  wire single_addr_w = is_single_addr_w && cnt_eff_w <= `CNT_ADDR_LAST;
  wire dual_addr_w = is_dual_io_w && cnt_eff_w <= `CNT_DUAL_ADDR_LAST;
  wire dual_mode_w = is_dual_io_w && cnt_eff_w > `CNT_DUAL_ADDR_LAST && cnt_eff_w <= `CNT_DUAL_MODE_LAST;
  wire pp_data_w = op_done_w && op_r == `OP_PAGE_PROGRAM && !ignore_r && cnt_eff_w >= `CNT_ADDR_DONE;
  wire pp_byte_w = pp_data_w && cnt_eff_w[2:0] == 3'h7;
  wire [7:0] pp_byte_val_w = {pp_sh_r[6:0], dual_line_zero_in};

  // Read data path on the falling edge
  wire rd_op_w = op_done_w && rd_start(op_r) != `CNT_MAX;
  wire dual_w = dual_data_op(op_r);
  wire rd_go_w = frame_r && rd_op_w && !ignore_r && cnt_r >= rd_start(op_r);
  wire pos_wrap_w = dual_w ? rd_pos_r == 3'h3 : rd_pos_r == 3'h7;
  wire [2:0] pos_nxt = (!rd_active_r || pos_wrap_w) ? 3'h0 : rd_pos_r + 3'h1;
  wire [`ADDR_W-1:0] rd_addr_nxt = !rd_active_r ? addr_r[`ADDR_W-1:0] :
    (pos_wrap_w ? rd_addr_r + `ADDR_W'h1 : rd_addr_r);
  wire [7:0] rd_byte_w = mem[rd_addr_nxt];
  wire [2:0] bit_hi_w = dual_w ? {pos_nxt[1:0], 1'b0} : pos_nxt;
  wire bit_one_w = rd_byte_w[3'h7 - bit_hi_w];
  wire bit_zero_w = rd_byte_w[3'h6 - bit_hi_w];

  // Frame start marker, cleared while chip select is high
  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      frame_r <= 1'b0;
    end else begin
      frame_r <= 1'b1;
    end
  end

  // Busy view on the serial clock
  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      busy_l1_r <= 1'b1;
      busy_l2_r <= 1'b1;
    end else begin
      busy_l1_r <= busy_r;
      busy_l2_r <= busy_l1_r;
    end
  end

  // Opcode, address and mode capture; held after chip select rises
  always_ff @(posedge serial_clock) begin
    cnt_r <= cnt_nxt;
    if (first_w) begin
      frame_tog_r <= ~frame_tog_r;
    end
    if (!op_done_w) begin
      op_r <= {op_r[6:0], dual_line_zero_in};
    end
    if (cnt_eff_w == `CNT_OPCODE_LAST) begin
      ignore_r <= busy_l2_r;
    end
    if (single_addr_w) begin
      addr_r <= {addr_r[22:0], dual_line_zero_in};
    end else if (dual_addr_w) begin
      addr_r <= {addr_r[21:0], dual_line_one_in, dual_line_zero_in};
    end
    if (dual_mode_w) begin
      mode_r <= {mode_r[5:0], dual_line_one_in, dual_line_zero_in};
    end
  end

  // Page data capture with in-page wrap
  always_ff @(posedge serial_clock) begin
    if (first_w) begin
      pp_mask_r <= 256'h0;
    end else if (pp_byte_w) begin
      pp_mask_r[pp_ptr_r] <= 1'b1;
    end
    if (pp_data_w) begin
      pp_sh_r <= pp_byte_val_w;
    end
    if (cnt_eff_w == `CNT_ADDR_LAST) begin
      pp_ptr_r <= {addr_r[6:0], dual_line_zero_in};
    end else if (pp_byte_w) begin
      pp_ptr_r <= pp_ptr_r + 8'h01;
    end
  end

  always_ff @(posedge serial_clock) begin
    if (pp_byte_w) begin
      pbuf[pp_ptr_r] <= pp_byte_val_w;
    end
  end

  // Output shifter on the falling edge, released while chip select is high
  always_ff @(negedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      rd_active_r <= 1'b0;
      rd_pos_r <= 3'h0;
      rd_addr_r <= `ADDR_W'h0;
      dual_line_one_out <= 1'b0;
      dual_line_one_oe <= 1'b0;
      dual_line_zero_out <= 1'b0;
      dual_line_zero_oe <= 1'b0;
    end else if (rd_go_w) begin
      rd_active_r <= 1'b1;
      rd_pos_r <= pos_nxt;
      rd_addr_r <= rd_addr_nxt;
      dual_line_one_out <= bit_one_w;
      dual_line_one_oe <= 1'b1;
      dual_line_zero_out <= dual_w & bit_zero_w;
      dual_line_zero_oe <= dual_w;
    end
  end

  // Chip select into the system clock
  always_ff @(posedge clock) begin
    if (srst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= chip_select_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  // Handover of a finished frame; link state is static while chip select is high
  wire cs_rise_w = cs_s2_r & ~cs_s3_r;
  wire new_frame_w = cs_rise_w && frame_tog_r != seen_tog_r;
  wire [2:0] bp_w = {block_protect_2, block_protect_1, block_protect_0};
  wire frame_ok_w = new_frame_w && cnt_r > `CNT_OPCODE_LAST && !ignore_r;
  wire pp_req_w = frame_ok_w && op_r == `OP_PAGE_PROGRAM && cnt_r >= `CNT_FIRST_BYTE_DONE &&
    cnt_r[2:0] == 3'h0;
  wire se_req_w = frame_ok_w && op_r == `OP_SECTOR_ERASE && cnt_r == `CNT_ADDR_DONE;
  wire be_req_w = frame_ok_w && op_r == `OP_BLOCK_ERASE && cnt_r == `CNT_ADDR_DONE;
  wire [`ADDR_W-1:0] pp_base_w = {addr_r[`ADDR_W-1:8], 8'h00};
  wire [`ADDR_W-1:0] se_base_w = {addr_r[`ADDR_W-1:12], 12'h000};
  wire [`ADDR_W-1:0] be_base_w = {addr_r[`ADDR_W-1:16], 16'h0000};
  wire [`ADDR_W-1:0] req_base_w = pp_req_w ? pp_base_w : (se_req_w ? se_base_w : be_base_w);
  wire [16:0] req_last_w = pp_req_w ? `PAGE_LAST : (se_req_w ? `SECTOR_LAST : `BLOCK_LAST);
  wire req_prot_w = prot_hit(req_base_w, req_last_w, sector_granular_protect, top_bottom_protect, bp_w);
  wire can_start_w = state_r == ST_IDLE && wel_r && !status_write_busy && !req_prot_w;
  wire start_pp_w = pp_req_w && can_start_w;
  wire start_er_w = (se_req_w || be_req_w) && can_start_w;
  wire walk_end_w = ptr_r == last_r;
  wire done_w = state_r != ST_IDLE && walk_end_w;
  wire [`ADDR_W-1:0] walk_addr_w = base_r + {4'h0, ptr_r};

  always_comb begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    case (state_r)
      ST_IDLE: begin
        ptr_nxt = 17'h0_0000;
        if (start_pp_w) begin
          state_nxt = ST_PROG;
        end else if (start_er_w) begin
          state_nxt = ST_ERASE;
        end
      end
      ST_PROG, ST_ERASE: begin
        ptr_nxt = ptr_r + 17'h0_0001;
        if (walk_end_w) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Set wins over completion and write disable
  assign wel_nxt = write_enable_set ? 1'b1 : ((write_enable_clear || done_w) ? 1'b0 : wel_r);

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_IDLE;
      ptr_r <= 17'h0_0000;
      seen_tog_r <= 1'b0;
      wel_r <= 1'b0;
      busy_r <= 1'b0;
      base_r <= `ADDR_W'h0;
      last_r <= 17'h0_0000;
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      wel_r <= wel_nxt;
      busy_r <= state_nxt != ST_IDLE || status_write_busy;
      if (new_frame_w) begin
        seen_tog_r <= frame_tog_r;
      end
      if (start_pp_w || start_er_w) begin
        base_r <= req_base_w;
        last_r <= req_last_w;
      end
    end
  end

  // Array updates: program ANDs into erased cells, erase fills with ones
  always_ff @(posedge clock) begin
    if (state_r == ST_PROG && pp_mask_r[ptr_r[7:0]]) begin
      mem[walk_addr_w] <= mem[walk_addr_w] & pbuf[ptr_r[7:0]];
    end else if (state_r == ST_ERASE) begin
      mem[walk_addr_w] <= `ERASED_BYTE;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
    end else begin
      write_enable_latch <= wel_nxt;
      busy <= state_nxt != ST_IDLE || status_write_busy;
    end
  end

endmodule : spi_flash_read_program_erase

// [hw/flash_seq_cfg.svh]
// Constants for the serial flash read, program and erase sequencer.
// Assumes a 2 MB array, a 256 byte page and a mode 0 or mode 3 serial link.
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// Opcodes
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_DUAL_OUT_READ 8'h3B
`define OP_DUAL_IO_READ 8'hBB
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hD8

// Array geometry
`define ADDR_W 21
`define MEM_BYTES 22'h20_0000
`define MEM_DEPTH 2097152
`define PAGE_LAST 17'h0_00FF
`define SECTOR_LAST 17'h0_0FFF
`define BLOCK_LAST 17'h0_FFFF
`define SECTOR_SIZE 22'h00_1000
`define BLOCK_SIZE 22'h01_0000
`define ERASED_BYTE 8'hFF

// Rising edge counts within a frame
`define CNT_OPCODE_LAST 16'h0007
`define CNT_ADDR_LAST 16'h001F
`define CNT_DUAL_ADDR_LAST 16'h0013
`define CNT_DUAL_MODE_LAST 16'h0017
`define CNT_ADDR_DONE 16'h0020
`define CNT_FIRST_BYTE_DONE 16'h0028
`define CNT_MAX 16'hFFFF

// Falling edge after which read data starts
`define RD_START_NORMAL 16'h0020
`define RD_START_FAST 16'h0028
`define RD_START_DUAL_IO 16'h0018

`endif

// [hw/flash_seq_pkg.sv]
// Types for the serial flash read, program and erase sequencer.
// Assumes flash_seq_cfg.svh for all numeric constants.
package flash_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_ERASE = 2'b10
  } core_state_t;

endpackage : flash_seq_pkg

// [dv/flash_properties.sv]
// Port checker for the flash sequencer.
// Assumes it is bound to the sequencer top.
`timescale 1ns/1ps
module flash_properties (
  // System side
  input logic clock,
  input logic srst,
  input logic write_enable_set,
  input logic status_write_busy,
  input logic block_protect_2,
  input logic block_protect_1,
  input logic block_protect_0,
  input logic write_enable_latch,
  input logic busy,
  // Link side
  input logic serial_clock,
  input logic chip_select_n,
  input logic dual_line_zero_oe,
  input logic dual_line_one_oe
);
  // Start of a self-timed cycle
  sequence s_walk_start;
    $rose(busy) && !$past(status_write_busy);
  endsequence
  a_cs_quiet: assert property (@(posedge clock) disable iff (srst)
    chip_select_n |-> !dual_line_one_oe && !dual_line_zero_oe) else $error("link driven while idle");
  a_set_latch: assert property (@(posedge clock) disable iff (srst)
    write_enable_set && !busy |=> write_enable_latch) else $error("latch not set");
  a_end_clears: assert property (@(posedge clock) disable iff (srst)
    $fell(busy) && !$past(status_write_busy, 2) |-> !write_enable_latch) else $error("latch kept");
  a_status_busy: assert property (@(posedge clock) disable iff (srst)
    status_write_busy |=> busy) else $error("busy low in status write");
  a_walk_hold: assert property (@(posedge clock) disable iff (srst)
    s_walk_start |-> busy [*8]) else $error("cycle too short");
  a_walk_latch: assert property (@(posedge clock) disable iff (srst)
    s_walk_start |-> write_enable_latch) else $error("cycle without latch");
  a_walk_prot: assert property (@(posedge clock) disable iff (srst)
    s_walk_start |-> !(block_protect_2 && block_protect_1 && block_protect_0)) else $error("protected cycle");
  a_busy_read: assert property (@(posedge clock) disable iff (srst)
    $rose(dual_line_one_oe) |-> !busy) else $error("read answered while busy");
endmodule : flash_properties

// [dv/host_link.sv]
// Host link model: chip select, gated serial clock, shared lines.
// Assumes mode 0 timing with a 48 ns link period.
`timescale 1ns/1ps
module host_link (
  // Host drive
  output logic serial_clock,
  output logic chip_select_n,
  output logic dual_line_zero_in,
  output logic dual_line_one_in,
  // Device drive
  input logic dual_line_zero_out,
  input logic dual_line_zero_oe,
  input logic dual_line_one_out,
  input logic dual_line_one_oe
);
  logic h0 = 1'b0;
  logic h1 = 1'b0;
  logic r0;
  logic r1;
  logic seen_oe;
  // Released host lines yield to the device
  assign dual_line_zero_in = dual_line_zero_oe ? dual_line_zero_out : h0;
  assign dual_line_one_in = dual_line_one_oe ? dual_line_one_out : h1;
  initial begin
    serial_clock = 1'b0;
    #1 chip_select_n = 1'b1;
  end
  task automatic tick(input logic b1, input logic b0);
    h1 = b1;
    h0 = b0;
    #24;
    r1 = dual_line_one_in;
    r0 = dual_line_zero_in;
    seen_oe = seen_oe | dual_line_one_oe;
    serial_clock = 1'b1;
    #24;
    serial_clock = 1'b0;
  endtask : tick
  task automatic start();
    #0.3;
    seen_oe = 1'b0;
    chip_select_n = 1'b0;
  endtask : start
  task automatic send(input logic [31:0] v, input int n, input bit dual);
    for (int i = n - 1; i >= 0; i--) begin
      if (dual) tick(v[2*i+1], v[2*i]);
      else tick(~h1, v[i]);
    end
  endtask : send
  task automatic get(input bit dual, output logic [7:0] q);
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      tick(~h1, ~h0);
      q = dual ? {q[5:0], r1, r0} : {q[6:0], r1};
    end
  endtask : get
  task automatic stop();
    #24;
    chip_select_n = 1'b1;
    h0 = ~h0;
    #250;
  endtask : stop
endmodule : host_link

// [dv/spi_flash_read_program_erase_test.sv]
// Bench for the flash sequencer with host link model and checker.
// Assumes flash_seq_cfg.svh is on the include path.
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module spi_flash_read_program_erase_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic write_enable_set = 1'b0;
  logic write_enable_clear = 1'b0;
  logic status_write_busy = 1'b0;
  logic [4:0] prot = 5'h00;
  int miscompares = 0;
  int cmp_count = 0;
  wire write_enable_latch, busy, serial_clock, chip_select_n;
  wire dual_line_zero_in, dual_line_zero_out, dual_line_zero_oe;
  wire dual_line_one_in, dual_line_one_out, dual_line_one_oe;
  always #12.5 clock = ~clock;
  spi_flash_read_program_erase spi_flash_read_program_erase_i (
    .clock, .srst, .write_enable_set, .write_enable_clear, .status_write_busy,
    .sector_granular_protect(prot[4]), .top_bottom_protect(prot[3]),
    .block_protect_2(prot[2]), .block_protect_1(prot[1]), .block_protect_0(prot[0]),
    .write_enable_latch, .busy, .serial_clock, .chip_select_n,
    .dual_line_zero_in, .dual_line_zero_out, .dual_line_zero_oe,
    .dual_line_one_in, .dual_line_one_out, .dual_line_one_oe);
  host_link host_link_i (
    .serial_clock, .chip_select_n, .dual_line_zero_in, .dual_line_one_in,
    .dual_line_zero_out, .dual_line_zero_oe, .dual_line_one_out, .dual_line_one_oe);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic set_wel();
    @(posedge clock) write_enable_set <= 1'b1;
    @(posedge clock) write_enable_set <= 1'b0;
    @(posedge clock);
    #1 chk(write_enable_latch, 1'b1);
  endtask : set_wel
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [15:0] d, input int nb);
    host_link_i.start();
    host_link_i.send(op, 8, 1'b0);
    host_link_i.send(a, 24, 1'b0);
    host_link_i.send(d, nb, 1'b0);
    host_link_i.stop();
  endtask : cmd
  task automatic run_chk(input logic eb);
    int i;
    repeat (20) @(posedge clock);
    #1 chk(busy, eb);
    for (i = 0; i < 70000 && busy === 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (i == 70000) begin
      miscompares++;
      wrap_up();
    end
    if (eb) chk(write_enable_latch, 1'b0);
  endtask : run_chk
  task automatic read_chk(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] d;
    logic dl;
    dl = op == `OP_DUAL_OUT_READ || op == `OP_DUAL_IO_READ;
    host_link_i.start();
    host_link_i.send(op, 8, 1'b0);
    if (op == `OP_DUAL_IO_READ) host_link_i.send({a, 8'h00}, 16, 1'b1);
    else host_link_i.send(a, 24, 1'b0);
    if (op == `OP_FAST_READ || op == `OP_DUAL_OUT_READ) host_link_i.send(32'h0000_0000, 8, 1'b0);
    host_link_i.get(dl, d);
    chk(d, e0);
    host_link_i.get(dl, d);
    chk(d, e1);
    host_link_i.stop();
  endtask : read_chk
  task automatic s_block();
    set_wel();
    cmd(`OP_BLOCK_ERASE, 24'h00_8000, 16'h0000, 0);
    run_chk(1'b1);
    read_chk(`OP_READ, 24'h00_FFFE, 8'hFF, 8'hFF);
  endtask : s_block
  task automatic s_refuse();
    set_wel();
    @(posedge clock) write_enable_clear <= 1'b1;
    @(posedge clock) write_enable_clear <= 1'b0;
    @(posedge clock);
    #1 chk(write_enable_latch, 1'b0);
    cmd(`OP_PAGE_PROGRAM, 24'h00_0010, 16'h0000, 8);
    run_chk(1'b0);
    set_wel();
    @(posedge clock) prot <= 5'h07;
    cmd(`OP_PAGE_PROGRAM, 24'h00_0010, 16'h0000, 8);
    run_chk(1'b0);
    @(posedge clock) prot <= 5'h19;
    cmd(`OP_PAGE_PROGRAM, 24'h00_0010, 16'h0000, 8);
    run_chk(1'b0);
    @(posedge clock) prot <= 5'h11;
    cmd(`OP_PAGE_PROGRAM, 24'h1F_FF10, 16'h0000, 8);
    run_chk(1'b0);
    @(posedge clock) prot <= 5'h00;
    cmd(`OP_PAGE_PROGRAM, 24'h00_0010, 16'h0000, 12);
    run_chk(1'b0);
    cmd(`OP_SECTOR_ERASE, 24'h00_0000, 16'h0000, 8);
    run_chk(1'b0);
  endtask : s_refuse
  task automatic s_prog();
    cmd(`OP_PAGE_PROGRAM, 24'h00_00FF, 16'hA53C, 16);
    run_chk(1'b1);
    host_link_i.start();
    host_link_i.send(32'h0000_0000, 4, 1'b0);
    host_link_i.stop();
    read_chk(`OP_FAST_READ, 24'h00_00FF, 8'hA5, 8'hFF);
    read_chk(`OP_DUAL_OUT_READ, 24'h00_0000, 8'h3C, 8'hFF);
    read_chk(`OP_DUAL_IO_READ, 24'h00_0000, 8'h3C, 8'hFF);
  endtask : s_prog
  task automatic s_busy_read();
    logic [7:0] d;
    @(posedge clock) status_write_busy <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(busy, 1'b1);
    host_link_i.start();
    host_link_i.send(`OP_READ, 8, 1'b0);
    host_link_i.send(32'h0000_0000, 24, 1'b0);
    host_link_i.get(1'b0, d);
    host_link_i.stop();
    chk(host_link_i.seen_oe, 1'b0);
    @(posedge clock) status_write_busy <= 1'b0;
  endtask : s_busy_read
  task automatic s_sector();
    set_wel();
    cmd(`OP_SECTOR_ERASE, 24'h00_0123, 16'h0000, 0);
    run_chk(1'b1);
    read_chk(`OP_READ, 24'h00_00FF, 8'hFF, 8'hFF);
  endtask : s_sector
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    repeat (5) @(posedge clock);
    #1 chk(busy, 1'b0);
    chk(write_enable_latch, 1'b0);
    s_block();
    s_refuse();
    s_prog();
    s_busy_read();
    s_sector();
    wrap_up();
  end
endmodule : spi_flash_read_program_erase_test
bind spi_flash_read_program_erase flash_properties flash_properties_i (
  .clock, .srst, .write_enable_set, .status_write_busy, .block_protect_2, .block_protect_1,
  .block_protect_0, .write_enable_latch, .busy, .serial_clock, .chip_select_n,
  .dual_line_zero_oe, .dual_line_one_oe);
